// *** inc/rs485s_consts.svh ***
`ifndef RS485S_CONSTS_SVH
`define RS485S_CONSTS_SVH

// Bit timing
`define RS485S_CLK_HZ     40000000
`define RS485S_BAUD       9600
`define RS485S_OVS        16
`define RS485S_DIV        (`RS485S_CLK_HZ / (`RS485S_BAUD * `RS485S_OVS))
`define RS485S_SMP_MID    4'h7
`define RS485S_SMP_LAST   4'hf
`define RS485S_BIT_LAST   3'h7

// Packet delimiters
`define RS485S_ESCAPE     8'h10
`define RS485S_OPEN_MARK  8'h02
`define RS485S_CLOSE_MARK 8'h03
`define RS485S_CSUM_LAST  1'h1

`endif

// *** inc/rs485s_pkg.sv ***
`default_nettype none
package rs485s_pkg;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rs485s_rx_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_LEAD  = 3'b001,
		TX_START = 3'b010,
		TX_DATA  = 3'b011,
		TX_STOP  = 3'b100
	} rs485s_tx_t;

	typedef enum logic [2:0] {
		PK_HUNT = 3'b000,
		PK_OPEN = 3'b001,
		PK_DEST = 3'b010,
		PK_BODY = 3'b011,
		PK_CSUM = 3'b100
	} rs485s_pk_t;
endpackage
`default_nettype wire

// *** design/rs485s_tick.sv ***
`default_nettype none
module rs485s_tick #(
	parameter int DIV = 260
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Enable pulse
	output var  logic tick
);
	localparam logic [8:0] LAST = 9'(DIV - 1);
	logic [8:0] divCnt_reg;

	always_ff @(posedge core_clk) begin
		if (rst || divCnt_reg == LAST) begin
			divCnt_reg <= 9'h000;
		end else begin
			divCnt_reg <= divCnt_reg + 9'h001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tick <= 1'b0;
		end else begin
			tick <= (divCnt_reg == LAST);
		end
	end
endmodule
`default_nettype wire

// *** design/rs485s_link.sv ***
`include "rs485s_consts.svh"
`default_nettype none
module rs485s_link (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Transceiver side
	input  wire logic       rxLine,
	output var  logic       txLine,
	output var  logic       txDriveEn,
	// Unit address and indicator
	input  wire logic [7:0] unitAddr,
	output var  logic       linkUp,
	// Received query bytes
	output var  logic [7:0] rxData,
	output var  logic       rxValid,
	output var  logic       frameErr,
	output var  logic       queryDone,
	// Reply bytes
	input  wire logic [7:0] txData,
	input  wire logic       txValid,
	input  wire logic       txLast,
	output var  logic       txReady
);
	logic                tick;
	rs485s_pkg::rs485s_rx_t rxState_reg;
	rs485s_pkg::rs485s_tx_t txState_reg;
	rs485s_pkg::rs485s_pk_t pkState_reg;
	logic [3:0]          rxSmp_reg;
	logic [2:0]          rxBit_reg;
	logic [7:0]          rxShift_reg;
	logic                byteGood;
	logic                escPend_reg;
	logic                addrMatch_reg;
	logic                csumCnt_reg;
	logic                replyOpen_reg;
	logic [3:0]          txSmp_reg;
	logic [2:0]          txBit_reg;
	logic [7:0]          txShift_reg;
	logic                txLastByte_reg;
	logic                txAccept;
	logic                txCellEnd;

	rs485s_tick #(
		.DIV(`RS485S_DIV)
	) u_tick (
		.core_clk(core_clk),
		.rst     (rst),
		.tick    (tick)
	);

	// receiver held idle while we drive the pair
	always_ff @(posedge core_clk) begin
		if (rst || txDriveEn) begin
			rxState_reg <= rs485s_pkg::RX_IDLE;
			rxSmp_reg   <= 4'h0;
			rxBit_reg   <= 3'h0;
		end else if (tick) begin
			rxSmp_reg <= rxSmp_reg + 4'h1;
			unique case (rxState_reg)
				rs485s_pkg::RX_IDLE: begin
					rxSmp_reg <= 4'h0;
					if (!rxLine) begin
						rxState_reg <= rs485s_pkg::RX_START;
					end
				end
				rs485s_pkg::RX_START: begin
					if (rxSmp_reg == `RS485S_SMP_MID) begin
						rxSmp_reg   <= 4'h0;
						rxBit_reg   <= 3'h0;
						rxState_reg <= rxLine ? rs485s_pkg::RX_IDLE
							: rs485s_pkg::RX_DATA;
					end
				end
				rs485s_pkg::RX_DATA: begin
					if (rxSmp_reg == `RS485S_SMP_LAST) begin
						rxBit_reg <= rxBit_reg + 3'h1;
						if (rxBit_reg == `RS485S_BIT_LAST) begin
							rxState_reg <= rs485s_pkg::RX_STOP;
						end
					end
				end
				rs485s_pkg::RX_STOP: begin
					if (rxSmp_reg == `RS485S_SMP_LAST) begin
						rxState_reg <= rs485s_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	// bit 0 arrives first, so shift in from the top
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rxShift_reg <= 8'h00;
		end else if (tick && rxState_reg == rs485s_pkg::RX_DATA
				&& rxSmp_reg == `RS485S_SMP_LAST) begin
			rxShift_reg <= {rxLine, rxShift_reg[7:1]};
		end
	end

	wire stopSample = !txDriveEn && tick && rxState_reg == rs485s_pkg::RX_STOP
		&& rxSmp_reg == `RS485S_SMP_LAST;
	assign byteGood = stopSample && rxLine;

	// framing error flagged, byte not passed on
	always_ff @(posedge core_clk) begin
		if (rst) begin
			frameErr <= 1'b0;
		end else begin
			frameErr <= stopSample && !rxLine;
		end
	end

	// delimiter tracking; a bad byte drops the packet
	// address compare on the destination byte
	// checksum bytes counted high byte first
	always_ff @(posedge core_clk) begin
		if (rst || frameErr) begin
			pkState_reg   <= rs485s_pkg::PK_HUNT;
			escPend_reg   <= 1'b0;
			addrMatch_reg <= 1'b0;
			csumCnt_reg   <= 1'b0;
		end else if (byteGood) begin
			unique case (pkState_reg)
				rs485s_pkg::PK_HUNT: begin
					if (rxLine && rxShift_reg == `RS485S_ESCAPE) begin
						pkState_reg <= rs485s_pkg::PK_OPEN;
					end
				end
				rs485s_pkg::PK_OPEN: begin
					if (rxShift_reg == `RS485S_OPEN_MARK) begin
						pkState_reg <= rs485s_pkg::PK_DEST;
					end else if (rxShift_reg != `RS485S_ESCAPE) begin
						pkState_reg <= rs485s_pkg::PK_HUNT;
					end
				end
				rs485s_pkg::PK_DEST: begin
					addrMatch_reg <= (rxShift_reg == unitAddr);
					escPend_reg   <= 1'b0;
					pkState_reg   <= rs485s_pkg::PK_BODY;
				end
				rs485s_pkg::PK_BODY: begin
					if (escPend_reg) begin
						escPend_reg <= 1'b0;
						if (rxShift_reg == `RS485S_CLOSE_MARK) begin
							csumCnt_reg <= 1'b0;
							pkState_reg <= rs485s_pkg::PK_CSUM;
						end else if (rxShift_reg == `RS485S_OPEN_MARK) begin
							pkState_reg <= rs485s_pkg::PK_DEST;
						end
					end else if (rxShift_reg == `RS485S_ESCAPE) begin
						escPend_reg <= 1'b1;
					end
				end
				rs485s_pkg::PK_CSUM: begin
					csumCnt_reg <= 1'b1;
					if (csumCnt_reg == `RS485S_CSUM_LAST) begin
						pkState_reg <= rs485s_pkg::PK_HUNT;
					end
				end
				default: pkState_reg <= rs485s_pkg::PK_HUNT;
			endcase
		end
	end

	wire inOwnPacket = addrMatch_reg
		&& (pkState_reg == rs485s_pkg::PK_BODY
		|| pkState_reg == rs485s_pkg::PK_CSUM);
	wire packetEnd = byteGood && pkState_reg == rs485s_pkg::PK_CSUM
		&& csumCnt_reg == `RS485S_CSUM_LAST;

	// only own traffic is flagged valid; rxData takes every good byte
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rxData    <= 8'h00;
			rxValid   <= 1'b0;
			queryDone <= 1'b0;
		end else begin
			rxValid   <= byteGood && inOwnPacket;
			queryDone <= packetEnd && addrMatch_reg;
			if (byteGood) begin
				rxData <= rxShift_reg;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			linkUp <= 1'b0;
		end else if (queryDone) begin
			linkUp <= 1'b1;
		end
	end

	assign txCellEnd = tick && txSmp_reg == `RS485S_SMP_LAST;
	wire replyEnd = txCellEnd && txState_reg == rs485s_pkg::TX_STOP
		&& txLastByte_reg;

	// replies only after an own query
	// window closes after the one reply; a new query wins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			replyOpen_reg <= 1'b0;
		end else if (queryDone) begin
			replyOpen_reg <= 1'b1;
		end else if (replyEnd) begin
			replyOpen_reg <= 1'b0;
		end
	end

	assign txAccept = txReady && txValid;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			txReady <= 1'b0;
		end else begin
			txReady <= replyOpen_reg && !queryDone && !txAccept
				&& txState_reg == rs485s_pkg::TX_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			txState_reg    <= rs485s_pkg::TX_IDLE;
			txSmp_reg      <= 4'h0;
			txBit_reg      <= 3'h0;
			txShift_reg    <= 8'h00;
			txLastByte_reg <= 1'b0;
		end else if (txAccept) begin
			txShift_reg    <= txData;
			txLastByte_reg <= txLast;
			txSmp_reg      <= 4'h0;
			txState_reg    <= rs485s_pkg::TX_LEAD;
		end else if (tick && txState_reg != rs485s_pkg::TX_IDLE) begin
			txSmp_reg <= txSmp_reg + 4'h1;
			if (txCellEnd) begin
				unique case (txState_reg)
					rs485s_pkg::TX_LEAD: txState_reg <= rs485s_pkg::TX_START;
					rs485s_pkg::TX_START: begin
						txBit_reg   <= 3'h0;
						txState_reg <= rs485s_pkg::TX_DATA;
					end
					rs485s_pkg::TX_DATA: begin
						txBit_reg   <= txBit_reg + 3'h1;
						txShift_reg <= {1'b1, txShift_reg[7:1]};
						if (txBit_reg == `RS485S_BIT_LAST) begin
							txState_reg <= rs485s_pkg::TX_STOP;
						end
					end
					rs485s_pkg::TX_STOP: txState_reg <= rs485s_pkg::TX_IDLE;
					default: txState_reg <= rs485s_pkg::TX_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			txLine <= 1'b1;
		end else begin
			unique case (txState_reg)
				rs485s_pkg::TX_START: txLine <= 1'b0;
				rs485s_pkg::TX_DATA:  txLine <= txShift_reg[0];
				default:              txLine <= 1'b1;
			endcase
		end
	end

	// enable leads the first start bit by one cell
	// held across the reply so nobody else grabs the pair
	always_ff @(posedge core_clk) begin
		if (rst || replyEnd) begin
			txDriveEn <= 1'b0;
		end else if (txAccept) begin
			txDriveEn <= 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_leadToStart;
		txState_reg == rs485s_pkg::TX_LEAD
			##1 txState_reg == rs485s_pkg::TX_START;
	endsequence

	sequence s_stopCell;
		txState_reg == rs485s_pkg::TX_STOP ##1 txState_reg == rs485s_pkg::TX_STOP;
	endsequence

	a_enable_leads: assert property (
		s_leadToStart |-> txDriveEn ##1 (!txLine && txDriveEn))
		else $error("start bit without driver enable");
	a_stop_high: assert property (
		s_stopCell |-> ##1 txLine)
		else $error("stop cell not high");
	a_talk_only_reply: assert property (
		txDriveEn |-> replyOpen_reg || $past(replyOpen_reg))
		else $error("driving without a query");
	a_one_reply: assert property (
		$fell(replyOpen_reg) && !queryDone |-> !txReady [*3])
		else $error("reply window reopened without a query");
	a_rx_muted: assert property (
		txDriveEn |-> ##2 !rxValid)
		else $error("receiving while driving");
	a_link_sticky: assert property (
		queryDone |=> linkUp [*4])
		else $error("indicator not lit after a query");
	a_frame_drop: assert property (
		frameErr |-> !rxValid ##1 !queryDone)
		else $error("framing error byte passed on");
	a_baud_spacing: assert property (
		tick |=> !tick [*8])
		else $error("baud enable too frequent");
	a_own_only: assert property (
		rxValid |-> $past(addrMatch_reg))
		else $error("foreign packet byte delivered");
	a_release_end: assert property (
		replyEnd |=> !txDriveEn && txLine)
		else $error("driver not released after last stop");
endmodule
`default_nettype wire

// *** verification/rs485s_xpdr_model.sv ***
`default_nettype none
module rs485s_xpdr_model (
	// Clock
	input  wire logic core_clk,
	// Device side of the pair
	input  wire logic txLine,
	input  wire logic txDriveEn,
	// Own drive onto the pair
	output var  logic xpLine,
	output var  logic xpDrive
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CELL = 4160;
	logic [7:0] got [$];
	logic [7:0] b;
	initial begin
		xpLine = 1'b1;
		xpDrive = 1'b0;
	end
	task automatic send_byte(input logic [7:0] d, input logic stopBit);
		while (txDriveEn !== 1'b0) @(posedge core_clk);
		@(posedge core_clk);
		xpDrive <= 1'b1;
		xpLine <= 1'b0;
		repeat (CELL) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			xpLine <= d[i];
			repeat (CELL) @(posedge core_clk);
		end
		xpLine <= stopBit;
		repeat (CELL) @(posedge core_clk);
		// Released pair falls back to the bias level
		xpLine <= 1'b1;
		xpDrive <= 1'b0;
		@(posedge core_clk);
	endtask
	always begin
		@(posedge core_clk);
		if (txDriveEn === 1'b1 && txLine === 1'b0) begin
			repeat (CELL / 2) @(posedge core_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (CELL) @(posedge core_clk);
				b[i] = txLine;
			end
			repeat (CELL) @(posedge core_clk);
			got.push_back(b);
		end
	end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] unitAddr = 8'h03;
	logic [7:0] txData = 8'h00;
	logic       txValid = 1'b0;
	logic       txLast = 1'b0;
	logic [7:0] rxData;
	logic [7:0] firstData;
	logic       txLine, txDriveEn, linkUp, rxValid, frameErr;
	logic       queryDone, txReady, xpLine, xpDrive;
	wire        busLine;
	int         mismatches = 0;
	int         checked = 0;
	int         nValid = 0, nErr = 0, nDone = 0, clash = 0;

	always #12.5 core_clk = ~core_clk;
	// Undriven pair is held high by the bias resistors
	assign busLine = txDriveEn ? txLine : (xpDrive ? xpLine : 1'b1);

	rs485s_link rs485s_link_i (
		.core_clk(core_clk), .rst(rst), .rxLine(busLine),
		.txLine(txLine), .txDriveEn(txDriveEn), .unitAddr(unitAddr),
		.linkUp(linkUp), .rxData(rxData), .rxValid(rxValid),
		.frameErr(frameErr), .queryDone(queryDone), .txData(txData),
		.txValid(txValid), .txLast(txLast), .txReady(txReady)
	);
	rs485s_xpdr_model rs485s_xpdr_model_i (
		.core_clk(core_clk), .txLine(txLine), .txDriveEn(txDriveEn),
		.xpLine(xpLine), .xpDrive(xpDrive)
	);

	always @(posedge core_clk) begin
		if (rxValid === 1'b1) begin
			if (nValid == 0) firstData = rxData;
			nValid++;
		end
		if (frameErr === 1'b1) nErr++;
		if (queryDone === 1'b1) nDone++;
		if (txDriveEn === 1'b1 && xpDrive === 1'b1) clash++;
	end

	task automatic check(input string name, input logic [7:0] seen,
			input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			mismatches++;
		end
	endtask

	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic send_seq(input logic [7:0] s [$]);
		foreach (s[i]) rs485s_xpdr_model_i.send_byte(s[i], 1'b1);
		repeat (4000) @(posedge core_clk);
	endtask

	task automatic send_reply(input logic [7:0] d, input logic last);
		int n = 0;
		@(posedge core_clk);
		txData <= d;
		txValid <= 1'b1;
		txLast <= last;
		do begin
			@(posedge core_clk);
			n++;
		end while (txReady !== 1'b1 && n < 200000);
		txValid <= 1'b0;
		if (n >= 200000) mismatches++;
	endtask

	task automatic t_reset();
		@(posedge core_clk);
		#1;
		check("txLine", {7'h00, txLine}, 8'h01);
		check("txDriveEn", {7'h00, txDriveEn}, 8'h00);
		check("linkUp", {7'h00, linkUp}, 8'h00);
		check("txReady", {7'h00, txReady}, 8'h00);
	endtask

	task automatic t_frame_err();
		rs485s_xpdr_model_i.send_byte(8'h5a, 1'b0);
		repeat (4000) @(posedge core_clk);
		check("frameErr count", nErr[7:0], 8'h01);
		check("rxValid count", nValid[7:0], 8'h00);
	endtask

	task automatic t_foreign();
		send_seq('{8'h10, 8'h02, unitAddr + 8'h01, 8'h55});
		check("foreign rxValid", nValid[7:0], 8'h00);
		check("foreign linkUp", {7'h00, linkUp}, 8'h00);
		check("txDriveEn idle", {7'h00, txDriveEn}, 8'h00);
	endtask

	task automatic t_query();
		send_seq('{8'h10, 8'h02, unitAddr, 8'h5a, 8'h10, 8'h03,
			8'h12, 8'h34});
		check("queryDone count", nDone[7:0], 8'h01);
		check("first body byte", firstData, 8'h5a);
		check("low checksum last", rxData, 8'h34);
		check("linkUp", {7'h00, linkUp}, 8'h01);
	endtask

	task automatic t_reply();
		int n = 0;
		send_reply(8'ha5, 1'b0);
		send_reply(8'h3c, 1'b1);
		repeat (3) @(posedge core_clk);
		while (txDriveEn !== 1'b0 && n < 200000) begin
			@(posedge core_clk);
			n++;
		end
		repeat (10) @(posedge core_clk);
		n = rs485s_xpdr_model_i.got.size();
		check("reply count", n[7:0], 8'h02);
		check("reply byte 0", rs485s_xpdr_model_i.got[0], 8'ha5);
		check("reply byte 1", rs485s_xpdr_model_i.got[1], 8'h3c);
		check("txReady closed", {7'h00, txReady}, 8'h00);
		txValid <= 1'b1;
		repeat (6000) @(posedge core_clk);
		txValid <= 1'b0;
		check("no extra drive", {7'h00, txDriveEn}, 8'h00);
		check("idle line", {7'h00, txLine}, 8'h01);
		check("bus clash", clash[7:0], 8'h00);
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_frame_err();
		t_foreign();
		t_query();
		t_reply();
		close_out();
	end

	// Thirteen received and two sent characters, with margin
	initial begin
		repeat (1200000) @(posedge core_clk);
		mismatches++;
		close_out();
	end
endmodule
`default_nettype wire
